// *** bcrb_consts.svh ***
// register offsets, field positions and reset values of the config bank
`ifndef BCRB_CONSTS_SVH
`define BCRB_CONSTS_SVH
`define BCRB_ADDR_SPCFG 8'h00
`define BCRB_ADDR_RBSEL 8'h04
`define BCRB_ADDR_COMMIT 8'h05
`define BCRB_ADDR_RA_HI 8'h1F
`define BCRB_ADDR_RA_LO 8'h20
`define BCRB_ADDR_RA_SC 8'h21
`define BCRB_ADDR_RB_HI 8'h23
`define BCRB_ADDR_RB_LO 8'h24
`define BCRB_ADDR_RB_SC 8'h25
`define BCRB_ADDR_XO_HI 8'h27
`define BCRB_ADDR_XO_LO 8'h28
`define BCRB_ADDR_SWOV 8'h29
`define BCRB_ADDR_FIRST_CLOCK_OUTPUT 8'h32
`define BCRB_ADDR_SECOND_CLOCK_OUTPUT 8'h34
`define BCRB_NBUF 11
`define BCRB_RST_RA_HI 8'h40
`define BCRB_RST_RB_HI 8'h80
`define BCRB_RST_XO_HI 8'h40
`define BCRB_RST_OUT 8'hA8
`define BCRB_RST_ZERO 8'h00
`define BCRB_BIT_LSBF 6
`define BCRB_BIT_SRST 5
`define BCRB_BIT_MODE16 4
`define BCRB_BIT_SDO 7
`define BCRB_BIT_RBSEL 0
`define BCRB_BIT_COMMIT 0
`define BCRB_BIT_DIVEN 1
`define BCRB_BIT_OUTSRC 0
`define BCRB_OUTMODE_HI 5
`define BCRB_OUTMODE_LO 3
`endif

// *** bcrb_pkg.sv ***
// types shared by the config bank
package bcrb_pkg;
	typedef logic [7:0] bcrb_byte_t;
	typedef logic [13:0] bcrb_div_t;
	typedef logic [2:0] bcrb_mode_t;
endpackage

// *** bcrb_divsel.sv ***
// chooses between a register divider setting and a pin-derived setting
`timescale 1ns/1ps
module bcrb_divsel
#(
	parameter int WIDTH = 14
)
(
	input wire logic i_mclk,
	input wire logic i_rst_b,
	input wire logic i_use_reg,
	input wire logic [WIDTH-1:0] i_reg_val,
	input wire logic [WIDTH-1:0] i_pin_val,
	output logic [WIDTH-1:0] o_val
);
	always_ff @(posedge i_mclk)
	begin
		if (!i_rst_b)
			o_val <= '0;
		else if (i_use_reg)
			o_val <= i_reg_val;
		else
			o_val <= i_pin_val;
	end

	sel_track_a: assert property (@(posedge i_mclk)
		disable iff (!i_rst_b)
		i_use_reg |=> o_val == $past(i_reg_val))
		else $error("divider does not follow register value");
	pin_track_a: assert property (@(posedge i_mclk)
		disable iff (!i_rst_b)
		!i_use_reg |=> o_val == $past(i_pin_val))
		else $error("divider does not follow pin value");
endmodule

// *** bcrb_bank.sv ***
// buffered configuration register bank behind the serial port
`timescale 1ns/1ps
`include "bcrb_consts.svh"
module bcrb_bank
(
	input wire logic i_mclk,
	input wire logic i_rst_b,
	input wire logic i_wr_en,
	input wire logic i_rd_en,
	input wire logic [7:0] i_addr,
	input wire logic [7:0] i_wdata,
	input wire logic [13:0] i_pin_ra,
	input wire logic [13:0] i_pin_rb,
	input wire logic [13:0] i_pin_xo,
	input wire logic [2:0] i_pin_first_clock_output_mode,
	input wire logic [2:0] i_pin_second_clock_output_mode,
	output logic [7:0] o_rdata,
	output logic o_rvalid,
	output logic o_lsb_first,
	output logic [13:0] o_first_reference_input_div,
	output logic [13:0] o_second_reference_input_div,
	output logic [13:0] o_crystal_path_divider,
	output logic [7:0] o_ref_a_scaling,
	output logic [7:0] o_ref_b_scaling,
	output logic [7:0] o_switchover,
	output logic [2:0] o_first_clock_output_mode,
	output logic [2:0] o_second_clock_output_mode,
	output logic [7:0] o_first_clock_output_ctrl,
	output logic [7:0] o_second_clock_output_ctrl
);
	localparam int NBUF = `BCRB_NBUF;
	localparam logic [7:0] ADDRS [NBUF] = '{`BCRB_ADDR_RA_HI,
		`BCRB_ADDR_RA_LO, `BCRB_ADDR_RA_SC, `BCRB_ADDR_RB_HI,
		`BCRB_ADDR_RB_LO, `BCRB_ADDR_RB_SC, `BCRB_ADDR_XO_HI,
		`BCRB_ADDR_XO_LO, `BCRB_ADDR_SWOV, `BCRB_ADDR_FIRST_CLOCK_OUTPUT,
		`BCRB_ADDR_SECOND_CLOCK_OUTPUT};
	localparam logic [7:0] RSTV [NBUF] = '{`BCRB_RST_RA_HI,
		`BCRB_RST_ZERO, `BCRB_RST_ZERO, `BCRB_RST_RB_HI,
		`BCRB_RST_ZERO, `BCRB_RST_ZERO, `BCRB_RST_XO_HI,
		`BCRB_RST_ZERO, `BCRB_RST_ZERO, `BCRB_RST_OUT,
		`BCRB_RST_OUT};

	bcrb_pkg::bcrb_byte_t buf_ff [NBUF];
	bcrb_pkg::bcrb_byte_t act_ff [NBUF];
	logic lsbf_ff;
	logic rbsel_ff;
	logic commit_ff;
	logic srst_ff;
	logic [NBUF-1:0] hit;
	logic wr_ctl;
	logic wr_rb;
	logic wr_cm;
	logic do_commit;
	logic soft_rst;
	bcrb_pkg::bcrb_byte_t nxt_rdata;
	bcrb_pkg::bcrb_byte_t ctl_byte;
	bcrb_pkg::bcrb_div_t ra_reg;
	bcrb_pkg::bcrb_div_t rb_reg;
	bcrb_pkg::bcrb_div_t xo_reg;
	bcrb_pkg::bcrb_mode_t nxt_m1;
	bcrb_pkg::bcrb_mode_t nxt_m2;

	assign wr_ctl = i_wr_en && i_addr == `BCRB_ADDR_SPCFG;
	assign wr_rb = i_wr_en && i_addr == `BCRB_ADDR_RBSEL;
	assign wr_cm = i_wr_en && i_addr == `BCRB_ADDR_COMMIT;
	assign soft_rst = srst_ff;
	assign do_commit = commit_ff;

	// control byte: bit7 forced 0, bit4 forced 1, low nibble mirrors high
	always_comb
	begin
		ctl_byte[7:4] = {1'b0, lsbf_ff, srst_ff, 1'b1};
		ctl_byte[3:0] = {1'b0, lsbf_ff, srst_ff, 1'b1};
	end

	always_ff @(posedge i_mclk)
	begin
		if (!i_rst_b || soft_rst)
			lsbf_ff <= 1'b0;
		else if (wr_ctl)
			lsbf_ff <= i_wdata[`BCRB_BIT_LSBF];
	end

	always_ff @(posedge i_mclk)
	begin
		if (!i_rst_b)
			srst_ff <= 1'b0;
		else
			srst_ff <= wr_ctl && i_wdata[`BCRB_BIT_SRST];
	end

	always_ff @(posedge i_mclk)
	begin
		if (!i_rst_b || soft_rst)
			rbsel_ff <= 1'b0;
		else if (wr_rb)
			rbsel_ff <= i_wdata[`BCRB_BIT_RBSEL];
	end

	always_ff @(posedge i_mclk)
	begin
		if (!i_rst_b || soft_rst)
			commit_ff <= 1'b0;
		else
			commit_ff <= wr_cm && i_wdata[`BCRB_BIT_COMMIT];
	end

	genvar g;
	generate
		for (g = 0; g < NBUF; g++)
		begin : g_reg
			assign hit[g] = i_addr == ADDRS[g];
			always_ff @(posedge i_mclk)
			begin
				if (!i_rst_b || soft_rst)
					buf_ff[g] <= RSTV[g];
				else if (i_wr_en && hit[g])
					buf_ff[g] <= i_wdata;
			end
			always_ff @(posedge i_mclk)
			begin
				if (!i_rst_b || soft_rst)
					act_ff[g] <= RSTV[g];
				else if (do_commit)
					act_ff[g] <= buf_ff[g];
			end
		end
	endgenerate

	always_comb
	begin
		nxt_rdata = 8'h00;
		if (i_addr == `BCRB_ADDR_SPCFG)
			nxt_rdata = ctl_byte;
		else if (i_addr == `BCRB_ADDR_RBSEL)
			nxt_rdata = {7'h00, rbsel_ff};
		else if (i_addr == `BCRB_ADDR_COMMIT)
			nxt_rdata = {7'h00, commit_ff};
		else
			for (int i = 0; i < NBUF; i++)
				if (hit[i])
					nxt_rdata = rbsel_ff ? buf_ff[i] : act_ff[i];
	end

	always_ff @(posedge i_mclk)
	begin
		if (!i_rst_b)
		begin
			o_rdata <= 8'h00;
			o_rvalid <= 1'b0;
		end
		else
		begin
			o_rvalid <= i_rd_en;
			if (i_rd_en)
				o_rdata <= nxt_rdata;
		end
	end

	always_ff @(posedge i_mclk)
	begin
		if (!i_rst_b)
			o_lsb_first <= 1'b0;
		else
			o_lsb_first <= lsbf_ff;
	end

	assign ra_reg = {act_ff[0], act_ff[1][7:2]};
	assign rb_reg = {act_ff[3], act_ff[4][7:2]};
	assign xo_reg = {act_ff[6], act_ff[7][7:2]};

	bcrb_divsel #(.WIDTH(14)) u_ra
	(
		.i_mclk(i_mclk),
		.i_rst_b(i_rst_b),
		.i_use_reg(act_ff[1][`BCRB_BIT_DIVEN]),
		.i_reg_val(ra_reg),
		.i_pin_val(i_pin_ra),
		.o_val(o_first_reference_input_div)
	);
	bcrb_divsel #(.WIDTH(14)) u_rb
	(
		.i_mclk(i_mclk),
		.i_rst_b(i_rst_b),
		.i_use_reg(act_ff[4][`BCRB_BIT_DIVEN]),
		.i_reg_val(rb_reg),
		.i_pin_val(i_pin_rb),
		.o_val(o_second_reference_input_div)
	);
	bcrb_divsel #(.WIDTH(14)) u_xo
	(
		.i_mclk(i_mclk),
		.i_rst_b(i_rst_b),
		.i_use_reg(act_ff[7][`BCRB_BIT_DIVEN]),
		.i_reg_val(xo_reg),
		.i_pin_val(i_pin_xo),
		.o_val(o_crystal_path_divider)
	);

	// driver mode from register field when source bit set (active high)
	always_comb
	begin
		nxt_m1 = act_ff[9][`BCRB_BIT_OUTSRC] ?
			act_ff[9][`BCRB_OUTMODE_HI:`BCRB_OUTMODE_LO] : i_pin_first_clock_output_mode;
		nxt_m2 = act_ff[10][`BCRB_BIT_OUTSRC] ?
			act_ff[10][`BCRB_OUTMODE_HI:`BCRB_OUTMODE_LO] : i_pin_second_clock_output_mode;
	end

	always_ff @(posedge i_mclk)
	begin
		if (!i_rst_b)
		begin
			o_first_clock_output_mode <= 3'h0;
			o_second_clock_output_mode <= 3'h0;
			o_ref_a_scaling <= `BCRB_RST_ZERO;
			o_ref_b_scaling <= `BCRB_RST_ZERO;
			o_switchover <= `BCRB_RST_ZERO;
			o_first_clock_output_ctrl <= `BCRB_RST_OUT;
			o_second_clock_output_ctrl <= `BCRB_RST_OUT;
		end
		else
		begin
			o_first_clock_output_mode <= nxt_m1;
			o_second_clock_output_mode <= nxt_m2;
			o_ref_a_scaling <= act_ff[2];
			o_ref_b_scaling <= act_ff[5];
			o_switchover <= act_ff[8];
			o_first_clock_output_ctrl <= act_ff[9];
			o_second_clock_output_ctrl <= act_ff[10];
		end
	end

	ctl_fixed_a: assert property (@(posedge i_mclk)
		disable iff (!i_rst_b)
		i_rd_en && i_addr == `BCRB_ADDR_SPCFG |=> o_rdata[4] && o_rdata[0])
		else $error("mode bit not read as one");
	ctl_msb_zero_a: assert property (@(posedge i_mclk)
		disable iff (!i_rst_b)
		i_rd_en && i_addr == `BCRB_ADDR_SPCFG |=> !o_rdata[7] && !o_rdata[3])
		else $error("three-wire bit not zero");
	ctl_mirror_a: assert property (@(posedge i_mclk)
		disable iff (!i_rst_b)
		i_rd_en && i_addr == `BCRB_ADDR_SPCFG |=> o_rdata[3:0] == o_rdata[7:4])
		else $error("low nibble does not mirror");
	lsb_order_a: assert property (@(posedge i_mclk)
		disable iff (!i_rst_b)
		wr_ctl && !i_wdata[5] && !soft_rst |=> ##1
		o_lsb_first == $past(i_wdata[6], 2))
		else $error("shift order not taken");
	soft_reset_a: assert property (@(posedge i_mclk)
		disable iff (!i_rst_b)
		wr_ctl && i_wdata[5] |=> srst_ff ##1 (!srst_ff && !lsbf_ff
		&& buf_ff[0] == `BCRB_RST_RA_HI && !rbsel_ff))
		else $error("soft reset not applied or not self-cleared");
	buffer_hold_a: assert property (@(posedge i_mclk)
		disable iff (!i_rst_b)
		!do_commit && !soft_rst |=> $stable(act_ff[9]))
		else $error("active copy changed without commit");
	commit_copy_a: assert property (@(posedge i_mclk)
		disable iff (!i_rst_b)
		wr_cm && i_wdata[0] && !soft_rst |=> do_commit ##1
		(!commit_ff && act_ff[0] == $past(buf_ff[0])))
		else $error("commit did not copy or clear");
	read_active_a: assert property (@(posedge i_mclk)
		disable iff (!i_rst_b)
		i_rd_en && !rbsel_ff && hit[9] |=> o_rdata == $past(act_ff[9]))
		else $error("readback not from active copy");
	read_buffer_a: assert property (@(posedge i_mclk)
		disable iff (!i_rst_b)
		i_rd_en && rbsel_ff && hit[9] |=> o_rdata == $past(buf_ff[9]))
		else $error("readback not from buffer copy");
	out_mode_a: assert property (@(posedge i_mclk)
		disable iff (!i_rst_b)
		act_ff[9][0] |=> o_first_clock_output_mode == $past(act_ff[9][5:3]))
		else $error("output mode not from register field");

	commit_c: cover property (@(posedge i_mclk) disable iff (!i_rst_b)
		wr_cm && i_wdata[0]);
	srst_c: cover property (@(posedge i_mclk) disable iff (!i_rst_b)
		wr_ctl && i_wdata[5]);
	rdbuf_c: cover property (@(posedge i_mclk) disable iff (!i_rst_b)
		i_rd_en && rbsel_ff && hit[0]);
endmodule

// *** bcrb_host.sv ***
// host model that drives address, data and read/write enables of the config bank
`timescale 1ns/1ps
module bcrb_host
(
	input wire logic i_mclk,
	input wire logic i_rvalid,
	input wire logic [7:0] i_rdata,
	output logic o_wr_en,
	output logic o_rd_en,
	output logic [7:0] o_addr,
	output logic [7:0] o_wdata
);
	initial
	begin
		o_wr_en = 1'b0;
		o_rd_en = 1'b0;
		o_addr = 8'h00;
		o_wdata = 8'h00;
	end
	// released lines show the inverse of their last value
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(negedge i_mclk);
		o_wr_en = 1'b1;
		o_addr = a;
		o_wdata = d;
		@(negedge i_mclk);
		o_wr_en = 1'b0;
		o_addr = ~a;
		o_wdata = ~d;
	endtask
	// buffered writes only act after this strobe
	task automatic commit();
		wr(8'h05, 8'h01);
	endtask
	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		int n;
		@(negedge i_mclk);
		o_rd_en = 1'b1;
		o_addr = a;
		@(negedge i_mclk);
		o_rd_en = 1'b0;
		o_addr = ~a;
		n = 0;
		while (i_rvalid !== 1'b1 && n < 4)
		begin
			@(negedge i_mclk);
			n++;
		end
		d = (i_rvalid === 1'b1) ? i_rdata : 8'hXX;
	endtask
endmodule

// *** bcrb_bank_tb_top.sv ***
// self-checking bench for the buffered config register bank
`timescale 1ns/1ps
`define CHK(g, e) \
	begin \
		num_checks++; \
		if ((g) !== (e)) \
		begin \
			fail_count++; \
			$display("CHECK FAILED t=%0t got %h exp %h", $time, g, e); \
		end \
	end
module bcrb_bank_tb_top;
	typedef struct {
		logic [7:0] a;
		logic [7:0] r;
		logic [7:0] w;
	} bcrb_row_t;
	bcrb_row_t rows [11] = '{
		'{8'h1F, 8'h40, 8'h12}, '{8'h20, 8'h00, 8'h36},
		'{8'h21, 8'h00, 8'hF0}, '{8'h23, 8'h80, 8'h81},
		'{8'h24, 8'h00, 8'hFC}, '{8'h25, 8'h00, 8'hF0},
		'{8'h27, 8'h40, 8'h3C}, '{8'h28, 8'h00, 8'h06},
		'{8'h29, 8'h00, 8'hE0}, '{8'h32, 8'hA8, 8'h09},
		'{8'h34, 8'hA8, 8'hB0}};
	logic mclk = 1'b0;
	logic rst_b = 1'b0;
	logic wr_en, rd_en, rvalid, lsb;
	logic [7:0] addr, wdata, rdata, d, sc_a, sc_b, swov, c1, c2;
	logic [13:0] div_a, div_b, div_x;
	logic [2:0] m1, m2;
	int fail_count = 0;
	int num_checks = 0;
	always #10 mclk = ~mclk;
	bcrb_host host_u (.i_mclk(mclk), .i_rvalid(rvalid), .i_rdata(rdata),
		.o_wr_en(wr_en), .o_rd_en(rd_en), .o_addr(addr), .o_wdata(wdata));
	bcrb_bank dut_u (.i_mclk(mclk), .i_rst_b(rst_b), .i_wr_en(wr_en),
		.i_rd_en(rd_en), .i_addr(addr), .i_wdata(wdata),
		.i_pin_ra(14'h1111), .i_pin_rb(14'h2222), .i_pin_xo(14'h3333),
		.i_pin_first_clock_output_mode(3'h6), .i_pin_second_clock_output_mode(3'h5),
		.o_rdata(rdata), .o_rvalid(rvalid), .o_lsb_first(lsb),
		.o_first_reference_input_div(div_a),
		.o_second_reference_input_div(div_b),
		.o_crystal_path_divider(div_x), .o_ref_a_scaling(sc_a),
		.o_ref_b_scaling(sc_b), .o_switchover(swov),
		.o_first_clock_output_mode(m1), .o_second_clock_output_mode(m2),
		.o_first_clock_output_ctrl(c1), .o_second_clock_output_ctrl(c2));
	task automatic wrap_up();
		if (fail_count == 0 && num_checks > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	initial
	begin
		#100000;
		fail_count++;
		wrap_up();
	end
	initial
	begin
		repeat (3) @(posedge mclk);
		@(negedge mclk);
		`CHK(c1, 8'hA8);
		rst_b = 1'b1;
		repeat (3) @(negedge mclk);
		`CHK({div_a, div_b, m1}, {14'h1111, 14'h2222, 3'h6});
		host_u.rd(8'h00, d);
		`CHK(d, 8'h11);
		@(negedge mclk);
		`CHK(rvalid, 1'b0);
		host_u.wr(8'h00, 8'hC0);
		host_u.rd(8'h00, d);
		`CHK(d, 8'h55);
		`CHK(lsb, 1'b1);
		foreach (rows[i])
		begin
			host_u.rd(rows[i].a, d);
			`CHK(d, rows[i].r);
			host_u.wr(rows[i].a, rows[i].w);
			host_u.rd(rows[i].a, d);
			`CHK(d, rows[i].r);
		end
		`CHK({c1, div_a}, {8'hA8, 14'h1111});
		host_u.wr(8'h04, 8'h01);
		host_u.rd(8'h04, d);
		`CHK(d, 8'h01);
		foreach (rows[i])
		begin
			host_u.rd(rows[i].a, d);
			`CHK(d, rows[i].w);
		end
		host_u.commit();
		repeat (4) @(negedge mclk);
		host_u.rd(8'h05, d);
		`CHK(d, 8'h00);
		`CHK(div_a, 14'h048D);
		`CHK(div_b, 14'h2222);
		`CHK(div_x, 14'h0F01);
		`CHK({m1, m2}, {3'h1, 3'h5});
		`CHK({c1, c2, sc_a, sc_b, swov}, 40'h09B0F0F0E0);
		host_u.wr(8'h04, 8'h00);
		foreach (rows[i])
		begin
			host_u.rd(rows[i].a, d);
			`CHK(d, rows[i].w);
		end
		// unmapped place reads zero and ignores writes
		host_u.wr(8'h22, 8'hFF);
		host_u.rd(8'h22, d);
		`CHK(d, 8'h00);
		host_u.wr(8'h00, 8'h20);
		repeat (4) @(negedge mclk);
		host_u.rd(8'h00, d);
		`CHK(d, 8'h11);
		`CHK({lsb, c1, div_a}, {1'b0, 8'hA8, 14'h1111});
		host_u.rd(8'h1F, d);
		`CHK(d, 8'h40);
		wrap_up();
	end
endmodule
